// ==== rtl/tdx_regs.vh ====
// ==========================================================
// Operation
// - Insert register master-only; receive, override slave-only
// - Insert enable bit 16 starts delay insertion
// - Insert bits 14:8 select sequence number
// - Insert bits 7:0 select basic frame
// - Receive enable bit 16 starts delay extraction
// - Receive bits 14:8 give sequence number
// - Receive bits 7:0 give basic frame
// - Override enable ignores link delay information
// - Twelve-bit software delay used under override
// - Calibration runs only while enable set
`ifndef TDX_REGS_VH
`define TDX_REGS_VH
// ==========================================================
// Register byte offsets
`define TDX_CAL_CTRL_OFS 8'h60
`define TDX_INSERT_OFS 8'h68
`define TDX_EXTRACT_OFS 8'h6C
`define TDX_OVERRIDE_OFS 8'h70
`define TDX_ACTIVE_OFS 8'h74
// ==========================================================
// Field positions
`define TDX_EN_BIT 16
`define TDX_CAL_EN_BIT 0
`define TDX_SEQ_HI 14
`define TDX_SEQ_LO 8
`define TDX_BF_HI 7
`define TDX_BF_LO 0
`define TDX_USR_HI 11
`define TDX_USR_LO 0
// ==========================================================
// Reset values
`define TDX_SEQ_RST 7'h00
`define TDX_BF_RST 8'h00
`define TDX_USR_RST 12'h000
`endif

// ==== rtl/tdx_sync3.v ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Three-stage synchroniser, output moves when stages 2 and 3 agree
module tdx_sync3 (
  input wire sys_clk,
  input wire srst,
  input wire din,
  output reg dout
);
  reg s1_q; // First stage, read only by s2
  reg s2_q;
  reg s3_q;
  // Shift chain and agreement filter
  always @(posedge sys_clk) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/tdx_regbank.v ====
`timescale 1ns/1ps
`default_nettype none
`include "tdx_regs.vh"
// ==========================================================
// Transmit-delay exchange register bank, AHB-Lite slave
module tdx_regbank #(
  parameter IS_MASTER = 1, // 1: master variant, 0: slave variant
  parameter SEQ_W = 7,
  parameter BF_W = 8,
  parameter DLY_W = 12
) (
  input wire sys_clk,
  input wire srst,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire link_delay_valid_in, // Delay word seen on link, pin level
  input wire [DLY_W-1:0] link_delay_in, // Delay from the link, sampled on valid
  output reg cal_en_o,
  output reg insert_en_o,
  output reg [SEQ_W-1:0] insert_seq_o,
  output reg [BF_W-1:0] insert_bf_o,
  output reg extract_en_o,
  output reg [SEQ_W-1:0] extract_seq_o,
  output reg [BF_W-1:0] extract_bf_o,
  output reg [DLY_W-1:0] active_delay_o,
  output reg active_valid_o
);
  // ==========================================================
  // Storage
  reg cal_en_q; // Calibration enable
  reg ins_en_q;
  reg [SEQ_W-1:0] ins_seq_q;
  reg [BF_W-1:0] ins_bf_q;
  reg ext_en_q;
  reg [SEQ_W-1:0] ext_seq_q;
  reg [BF_W-1:0] ext_bf_q;
  reg usr_en_q;
  reg [DLY_W-1:0] usr_dly_q;
  reg [DLY_W-1:0] link_dly_q; // Last delay captured from the link
  reg link_got_q; // A link delay has been captured
  reg wr_pend_q; // Write address phase seen
  reg [7:0] wr_addr_q;
  reg link_vld_prev_q;
  wire link_vld_s; // Synchronised link valid
  wire wr_take;
  wire rd_take;
  wire link_rise;

  // Returns whether an offset belongs to this variant
  function mapped;
    input [7:0] a;
    begin
      if (a == `TDX_CAL_CTRL_OFS) begin
        mapped = 1'b1;
      end else if (a == `TDX_INSERT_OFS) begin
        mapped = (IS_MASTER != 0);
      end else if (a == `TDX_EXTRACT_OFS || a == `TDX_OVERRIDE_OFS ||
                   a == `TDX_ACTIVE_OFS) begin
        mapped = (IS_MASTER == 0);
      end else begin
        mapped = 1'b0;
      end
    end
  endfunction

  // Read mux; unused and reserved bits are zero
  function [31:0] rd_word;
    input [7:0] a;
    begin
      rd_word = 32'h00000000;
      if (mapped(a)) begin
        case (a)
          `TDX_CAL_CTRL_OFS: begin
            rd_word[`TDX_CAL_EN_BIT] = cal_en_q;
          end
          `TDX_INSERT_OFS: begin
            rd_word[`TDX_EN_BIT] = ins_en_q;
            rd_word[`TDX_SEQ_HI:`TDX_SEQ_LO] = ins_seq_q;
            rd_word[`TDX_BF_HI:`TDX_BF_LO] = ins_bf_q;
          end
          `TDX_EXTRACT_OFS: begin
            rd_word[`TDX_EN_BIT] = ext_en_q;
            rd_word[`TDX_SEQ_HI:`TDX_SEQ_LO] = ext_seq_q;
            rd_word[`TDX_BF_HI:`TDX_BF_LO] = ext_bf_q;
          end
          `TDX_OVERRIDE_OFS: begin
            rd_word[`TDX_EN_BIT] = usr_en_q;
            rd_word[`TDX_USR_HI:`TDX_USR_LO] = usr_dly_q;
          end
          `TDX_ACTIVE_OFS: begin
            rd_word[`TDX_EN_BIT] = active_valid_o;
            rd_word[`TDX_USR_HI:`TDX_USR_LO] = active_delay_o;
          end
          default: begin
            rd_word = 32'h00000000;
          end
        endcase
      end
    end
  endfunction

  // ==========================================================
  // Link valid pin synchroniser
  tdx_sync3 u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .din(link_delay_valid_in),
    .dout(link_vld_s)
  );

  assign wr_take = hsel && hready && htrans[1] && hwrite;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign link_rise = link_vld_s && !link_vld_prev_q;

  // ==========================================================
  // Bus handling: zero wait states, always OKAY
  always @(posedge sys_clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= wr_take;
      // Latch write address for the data phase
      if (wr_take) begin
        wr_addr_q <= {haddr[7:2], 2'b00};
      end
      // Read data presented during the data phase
      if (rd_take) begin
        hrdata <= rd_word({haddr[7:2], 2'b00});
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // ==========================================================
  // Register writes in the data phase
  always @(posedge sys_clk) begin
    if (srst) begin
      cal_en_q <= 1'b0;
      ins_en_q <= 1'b0;
      ins_seq_q <= `TDX_SEQ_RST;
      ins_bf_q <= `TDX_BF_RST;
      ext_en_q <= 1'b0;
      ext_seq_q <= `TDX_SEQ_RST;
      ext_bf_q <= `TDX_BF_RST;
      usr_en_q <= 1'b0;
      usr_dly_q <= `TDX_USR_RST;
    end else if (wr_pend_q && mapped(wr_addr_q)) begin
      case (wr_addr_q)
        `TDX_CAL_CTRL_OFS: begin
          cal_en_q <= hwdata[`TDX_CAL_EN_BIT];
        end
        `TDX_INSERT_OFS: begin
          ins_en_q <= hwdata[`TDX_EN_BIT];
          ins_seq_q <= hwdata[`TDX_SEQ_HI:`TDX_SEQ_LO];
          ins_bf_q <= hwdata[`TDX_BF_HI:`TDX_BF_LO];
        end
        `TDX_EXTRACT_OFS: begin
          ext_en_q <= hwdata[`TDX_EN_BIT];
          ext_seq_q <= hwdata[`TDX_SEQ_HI:`TDX_SEQ_LO];
          ext_bf_q <= hwdata[`TDX_BF_HI:`TDX_BF_LO];
        end
        `TDX_OVERRIDE_OFS: begin
          usr_en_q <= hwdata[`TDX_EN_BIT];
          usr_dly_q <= hwdata[`TDX_USR_HI:`TDX_USR_LO];
        end
        default: begin
          cal_en_q <= cal_en_q; // Read-only offsets ignore writes
        end
      endcase
    end
  end

  // ==========================================================
  // Link delay capture: only when extraction on and not overridden
  always @(posedge sys_clk) begin
    if (srst) begin
      link_vld_prev_q <= 1'b0;
      link_dly_q <= `TDX_USR_RST;
      link_got_q <= 1'b0;
    end else begin
      link_vld_prev_q <= link_vld_s;
      // Link data is assumed stable while valid is high
      if (link_rise && cal_en_q && ext_en_q && !usr_en_q) begin
        link_dly_q <= link_delay_in;
        link_got_q <= 1'b1;
      end else if (!cal_en_q) begin
        link_got_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Outputs to the framer and the delay calculation
  always @(posedge sys_clk) begin
    if (srst) begin
      cal_en_o <= 1'b0;
      insert_en_o <= 1'b0;
      insert_seq_o <= `TDX_SEQ_RST;
      insert_bf_o <= `TDX_BF_RST;
      extract_en_o <= 1'b0;
      extract_seq_o <= `TDX_SEQ_RST;
      extract_bf_o <= `TDX_BF_RST;
      active_delay_o <= `TDX_USR_RST;
      active_valid_o <= 1'b0;
    end else begin
      cal_en_o <= cal_en_q;
      // Insertion only in master builds with calibration running
      insert_en_o <= (IS_MASTER != 0) && cal_en_q && ins_en_q;
      insert_seq_o <= ins_seq_q;
      insert_bf_o <= ins_bf_q;
      // Override blocks extraction outright
      extract_en_o <= (IS_MASTER == 0) && cal_en_q && ext_en_q && !usr_en_q;
      extract_seq_o <= ext_seq_q;
      extract_bf_o <= ext_bf_q;
      // Select the delay fed to the calculation
      if (usr_en_q) begin
        active_delay_o <= usr_dly_q;
        active_valid_o <= (IS_MASTER == 0) && cal_en_q;
      end else begin
        active_delay_o <= link_dly_q;
        active_valid_o <= (IS_MASTER == 0) && cal_en_q && ext_en_q && link_got_q;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/tdx_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checks of the register bank, bound to every variant
module tdx_checker #(
  parameter IS_MASTER = 1,
  parameter SEQ_W = 7,
  parameter BF_W = 8,
  parameter DLY_W = 12
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic cal_en_o,
  input wire logic insert_en_o,
  input wire logic [SEQ_W-1:0] insert_seq_o,
  input wire logic [BF_W-1:0] insert_bf_o,
  input wire logic extract_en_o,
  input wire logic [SEQ_W-1:0] extract_seq_o,
  input wire logic [BF_W-1:0] extract_bf_o,
  input wire logic [DLY_W-1:0] active_delay_o,
  input wire logic active_valid_o
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Taken address phase of a write, gated by variant
  sequence s_wr(a, v);
    v && hsel && hready && htrans[1] && hwrite && haddr == a;
  endsequence
  // Fields land two edges after the data phase
  property p_ins;
    logic [31:0] d;
    (s_wr(8'h68, IS_MASTER != 0), d = 32'h0) ##1 (1, d = hwdata) |-> ##2
      insert_seq_o == d[14:8] && insert_bf_o == d[7:0] && insert_en_o == (d[16] && cal_en_o);
  endproperty
  property p_ext;
    logic [31:0] d;
    (s_wr(8'h6C, IS_MASTER == 0), d = 32'h0) ##1 (1, d = hwdata) |-> ##2
      extract_seq_o == d[14:8] && extract_bf_o == d[7:0];
  endproperty
  // Override wins over the link value while set
  property p_ovr;
    logic [31:0] d;
    (s_wr(8'h70, IS_MASTER == 0), d = 32'h0) ##1 (1, d = hwdata) |-> ##2 (d[16] ->
      !extract_en_o && active_valid_o == cal_en_o && active_delay_o == d[11:0]);
  endproperty
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus stalled or error response");
  AST_RST: assert property (disable iff (1'b0) srst |=>
    !cal_en_o && !insert_en_o && !extract_en_o && !active_valid_o && hrdata == 32'h0)
    else $error("outputs not cleared by reset");
  AST_INS: assert property (p_ins)
    else $error("insert fields do not follow write");
  AST_EXT: assert property (p_ext)
    else $error("extract fields do not follow write");
  AST_OVR: assert property (p_ovr)
    else $error("override value not active");
  AST_UNMAP: assert property (hsel && hready && htrans[1] && !hwrite && haddr == 8'h7C
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  AST_RSVD: assert property (hsel && hready && htrans[1] && !hwrite && haddr[7:4] == 4'h6
    |=> hrdata[31:17] == 15'h0 && hrdata[15] == 1'h0) else $error("reserved bits set");
  AST_INS_CAL: assert property (insert_en_o |-> IS_MASTER != 0 && cal_en_o)
    else $error("insert enabled without master or calibration");
  AST_SLV_CAL: assert property (extract_en_o || active_valid_o |->
    IS_MASTER == 0 && cal_en_o) else $error("slave path active without calibration");
  cover property (s_wr(8'h68, IS_MASTER != 0));
  cover property (s_wr(8'h70, IS_MASTER == 0));
  cover property ($rose(active_valid_o));
endmodule
`default_nettype wire

// ==== test/tdx_link_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far link end: raises the delay word, holds it, then releases
module tdx_link_peer (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [11:0] val,
  output logic vld,
  output logic [11:0] dly
);
  logic [4:0] hold_q = 5'h0; // Hold long enough for the 3-stage sync
  initial vld = 1'h0;
  initial dly = 12'hA5A;
  // Released word shows inverted data so a stale value cannot pass
  always @(posedge sys_clk) begin
    if (go && !vld) begin
      vld <= 1'h1;
      dly <= val;
      hold_q <= 5'h10;
    end else if (hold_q != 5'h0) begin
      hold_q <= hold_q - 5'h1;
    end else if (vld) begin
      vld <= 1'h0;
      dly <= ~dly;
    end
  end
endmodule
`default_nettype wire

// ==== test/tdx_regbank_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench: master and slave variant behind one bus, tgt picks one
module tdx_regbank_test;
  logic sys_clk;
  logic srst = 1'h1;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic tgt = 1'h1; // 1: master variant
  logic go = 1'h0;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] r;
  logic [11:0] val = 12'h0;
  wire logic vld, m_rdy, s_rdy, ins_en, ext_en, act_v;
  wire logic [11:0] dly, act_d;
  wire logic [31:0] m_rd, s_rd;
  wire logic [6:0] ins_seq, ext_seq;
  wire logic [7:0] ins_bf, ext_bf;
  wire logic hready = tgt ? m_rdy : s_rdy;
  wire logic [31:0] hrdata = tgt ? m_rd : s_rd;
  int num_errors = 0;
  int checks = 0;
  tdx_regbank #(.IS_MASTER(1)) i_tdx_regbank_m (.sys_clk, .srst, .hsel(hsel && tgt), .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(m_rdy), .hresp(), .hrdata(m_rd),
    .link_delay_valid_in(vld), .link_delay_in(dly), .cal_en_o(), .insert_en_o(ins_en),
    .insert_seq_o(ins_seq), .insert_bf_o(ins_bf), .extract_en_o(), .extract_seq_o(),
    .extract_bf_o(), .active_delay_o(), .active_valid_o());
  tdx_regbank #(.IS_MASTER(0)) i_tdx_regbank_s (.sys_clk, .srst, .hsel(hsel && !tgt), .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(s_rdy), .hresp(), .hrdata(s_rd),
    .link_delay_valid_in(vld), .link_delay_in(dly), .cal_en_o(), .insert_en_o(),
    .insert_seq_o(), .insert_bf_o(), .extract_en_o(ext_en), .extract_seq_o(ext_seq),
    .extract_bf_o(ext_bf), .active_delay_o(act_d), .active_valid_o(act_v));
  tdx_link_peer i_tdx_link_peer (.sys_clk, .go, .val, .vld, .dly);
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One single transfer; waits on hready with no assumed latency
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'h1);
    r = hrdata;
  endtask
  // Outputs follow register state one clock later
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk($sformatf("read %h", a), r, e);
  endtask
  task automatic send(input logic [11:0] v);
    val <= v;
    go <= 1'h1;
    @(posedge sys_clk);
    go <= 1'h0;
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    rd(8'h68, 32'h0);
    wr(8'h68, 32'hFFFFFFFF);
    chk("ins_en", ins_en, 32'h0);
    rd(8'h68, 32'h00017FFF);
    rd(8'h6C, 32'h0);
    wr(8'h60, 32'h1);
    chk("ins_en", ins_en, 32'h1);
    chk("ins_pos", {ins_seq, ins_bf}, 32'h7FFF);
    wr(8'h68, 32'h00012A5C);
    chk("ins_bf", ins_bf, 32'h5C);
    tgt <= 1'h0;
    rd(8'h6C, 32'h0);
    rd(8'h68, 32'h0);
    wr(8'h60, 32'h1);
    wr(8'h6C, 32'h00012A5C);
    chk("ext", {ext_en, ext_seq, ext_bf}, 32'hAA5C);
    send(12'h3C7);
    chk("act", {act_v, act_d}, 32'h13C7);
    wr(8'h70, 32'hFFFFFFFF);
    rd(8'h70, 32'h00010FFF);
    chk("ext_en", ext_en, 32'h0);
    send(12'h111);
    chk("act_d", act_d, 32'hFFF);
    rd(8'h7C, 32'h0);
    wr(8'h60, 32'h0);
    chk("act_v", {act_v, ext_en}, 32'h0);
    close_out();
  end
  // Whole run is under a hundred cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end
endmodule
bind tdx_regbank tdx_checker #(.IS_MASTER(IS_MASTER), .SEQ_W(SEQ_W), .BF_W(BF_W), .DLY_W(DLY_W))
  i_tdx_checker (.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .hrdata, .cal_en_o, .insert_en_o, .insert_seq_o, .insert_bf_o, .extract_en_o,
  .extract_seq_o, .extract_bf_o, .active_delay_o, .active_valid_o);
`default_nettype wire
